// >>> pdc_consts.vh
// constants for the pre-driver strength and monitor threshold bank
// assumes a 16-bit register port addressed by 9-bit register index
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH
// ****************************************
// register indices
// ****************************************
`define PDC_ADDR_HS_DRAIN   9'h18A
`define PDC_ADDR_HS_SOURCE  9'h18B
`define PDC_ADDR_LS_DRAIN_A 9'h18C
`define PDC_ADDR_LS_DRAIN_B 9'h18D
`define PDC_ADDR_LS_STRENGTH 9'h18F
// ****************************************
// reset values and field layout
// ****************************************
`define PDC_RST_THRESH      16'h0000
`define PDC_RST_STRENGTH    16'h0000
`define PDC_RST_SEL         28'h111_1111
`define PDC_STRENGTH_FAST   2'h0
`define PDC_CODE_W          3
`define PDC_NUM_HS          5
`define PDC_NUM_LS          7
`define PDC_NUM_LS_MON      6
`define PDC_HS_BOOST_MASK   5'h0A
// ****************************************
// timing
// ****************************************
`define PDC_CLK_PERIOD_NS   40
`define PDC_APPLY_MAX_NS    166
`define PDC_APPLY_CYC       ((`PDC_APPLY_MAX_NS / `PDC_CLK_PERIOD_NS) < 1 ? 1 : (`PDC_APPLY_MAX_NS / `PDC_CLK_PERIOD_NS))
`endif

// >>> pdc_strength_dec.v
// per-driver edge strength decoder with fast override
// assumes codes are registered by the caller
`timescale 1ns/100ps
`default_nettype none
module pdc_strength_dec (
  // configuration
  input  wire [1:0] rise_code,
  input  wire [1:0] fall_code,
  input  wire       fast_force,
  // decoded to the analog stage, one-hot per edge
  output reg  [3:0] rise_sel,
  output reg  [3:0] fall_sel
);
`include "pdc_consts.vh"
  reg [1:0] r_eff;
  reg [1:0] f_eff;
  always @* begin
    // override replaces, never overwrites, the stored codes
    r_eff = fast_force ? `PDC_STRENGTH_FAST : rise_code;
    f_eff = fast_force ? `PDC_STRENGTH_FAST : fall_code;
    // one-hot: bit0=300, bit1=50, bit2=25, bit3=12.5 V/us
    rise_sel = 4'h1 << r_eff;
    // falling leg sized from the slower of both codes, never faster than the rising leg
    fall_sel = 4'h1 << ((r_eff > f_eff) ? r_eff : f_eff);
  end
endmodule // pdc_strength_dec
`default_nettype wire

// >>> pdc_cfg_bank.v
// pre-driver edge strength and voltage monitor threshold bank
// assumes synchronous register port, microcode strobes on CLK_SYS
`timescale 1ns/100ps
`default_nettype none
module pdc_cfg_bank (
  // clock and reset
  input  wire        CLK_SYS,
  input  wire        SYS_RST,
  // register port
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [8:0]  REG_ADDR,
  input  wire [15:0] REG_WDATA,
  output reg  [15:0] REG_RDATA,
  output wire        REG_ERR,
  // microcode
  input  wire        UC_FAST_STRENGTH,
  input  wire        UC_THRESH_WR,
  input  wire [1:0]  UC_THRESH_SEL,
  input  wire [15:0] UC_THRESH_DATA,
  input  wire [4:0]  UC_HS_BOOST_REF,
  // device state
  input  wire        DEV_OPERATING,
  input  wire [6:0]  LS_CMD_IN,
  input  wire [4:0]  HS_SUPPLIED,
  input  wire [6:0]  LS_SUPPLIED,
  input  wire [4:0]  HS_STANDALONE,
  input  wire [4:0]  HS_DRAIN_CMP,
  input  wire [4:0]  HS_SOURCE_CMP,
  input  wire [5:0]  LS_DRAIN_CMP,
  // to the analog stages
  output wire [6:0]  LS_GATE,
  output reg  [27:0] LS_RISE_SEL,
  output reg  [27:0] LS_FALL_SEL,
  output reg  [14:0] HS_DRAIN_THRESH,
  output reg  [14:0] HS_SOURCE_THRESH,
  output reg  [17:0] LS_DRAIN_THRESH,
  output reg  [4:0]  HS_BOOST_REF,
  output reg  [4:0]  HS_DRIVER_USABLE,
  output reg  [4:0]  HS_DRAIN_FLAG,
  output reg  [4:0]  HS_SOURCE_FLAG,
  output reg  [5:0]  LS_DRAIN_FLAG,
  output reg         NORMAL_MODE
);
`include "pdc_consts.vh"
  // ****************************************
  // register storage
  // ****************************************
  reg [15:0] hs_drain_thresh_reg;
  reg [15:0] hs_source_thresh_reg;
  reg [15:0] ls_drain_thresh_reg_a;
  reg [15:0] ls_drain_thresh_reg_b;
  reg [15:0] ls_strength_cfg_reg;
  reg        fast_r;
  wire [27:0] rise_sel_w;
  wire [27:0] fall_sel_w;
  wire        hit;

  assign hit = (REG_ADDR == `PDC_ADDR_HS_DRAIN) || (REG_ADDR == `PDC_ADDR_HS_SOURCE) ||
               (REG_ADDR == `PDC_ADDR_LS_DRAIN_A) || (REG_ADDR == `PDC_ADDR_LS_DRAIN_B) ||
               (REG_ADDR == `PDC_ADDR_LS_STRENGTH);
  assign REG_ERR = (REG_WR | REG_RD) & ~hit;

  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      NORMAL_MODE <= 1'b0;
    end else begin
      NORMAL_MODE <= 1'b1;
    end
  end

  // register writes; microcode threshold write wins over a same-cycle spi write
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      hs_drain_thresh_reg   <= `PDC_RST_THRESH;
      hs_source_thresh_reg  <= `PDC_RST_THRESH;
      ls_drain_thresh_reg_a <= `PDC_RST_THRESH;
      ls_drain_thresh_reg_b <= `PDC_RST_THRESH;
      ls_strength_cfg_reg   <= `PDC_RST_STRENGTH;
    end else begin
      if (REG_WR) begin
        case (REG_ADDR)
          `PDC_ADDR_HS_DRAIN:    hs_drain_thresh_reg   <= REG_WDATA;
          `PDC_ADDR_HS_SOURCE:   hs_source_thresh_reg  <= REG_WDATA;
          `PDC_ADDR_LS_DRAIN_A:  ls_drain_thresh_reg_a <= REG_WDATA;
          `PDC_ADDR_LS_DRAIN_B:  ls_drain_thresh_reg_b <= REG_WDATA;
          `PDC_ADDR_LS_STRENGTH: begin
            if (NORMAL_MODE) begin
              ls_strength_cfg_reg <= REG_WDATA;
            end
          end
          default: ;
        endcase
      end
      if (UC_THRESH_WR) begin
        case (UC_THRESH_SEL)
          2'h0: hs_drain_thresh_reg   <= UC_THRESH_DATA;
          2'h1: hs_source_thresh_reg  <= UC_THRESH_DATA;
          2'h2: ls_drain_thresh_reg_a <= UC_THRESH_DATA;
          default: ls_drain_thresh_reg_b <= UC_THRESH_DATA;
        endcase
      end
    end
  end

  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      fast_r <= 1'b0;
    end else begin
      fast_r <= UC_FAST_STRENGTH;
    end
  end

  // ****************************************
  // strength decode, 7 drivers
  // ****************************************
  // 16-bit register holds 8 codes; rise codes in [7:0] for drivers 0..3,
  // fall codes in [15:8]; drivers 4..6 reuse the codes of drivers 0..2 in the same fields
  genvar g;
  generate
    for (g = 0; g < `PDC_NUM_LS; g = g + 1) begin : g_ls
      wire [1:0] rc;
      wire [1:0] fc;
      assign rc = ls_strength_cfg_reg[2*(g%4) +: 2];
      assign fc = ls_strength_cfg_reg[8 + 2*(g%4) +: 2];
      pdc_strength_dec u_dec (
        .rise_code  (rc),
        .fall_code  (fc),
        .fast_force (fast_r),
        .rise_sel   (rise_sel_w[4*g +: 4]),
        .fall_sel   (fall_sel_w[4*g +: 4])
      );
    end
  endgenerate

  // one flop from code change to driver select
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      LS_RISE_SEL <= `PDC_RST_SEL;
      LS_FALL_SEL <= `PDC_RST_SEL;
    end else begin
      LS_RISE_SEL <= rise_sel_w;
      LS_FALL_SEL <= fall_sel_w;
    end
  end

  // combinational so the gate drops the instant reset rises
  assign LS_GATE = (SYS_RST | ~DEV_OPERATING) ? 7'h00 : LS_CMD_IN;

  // ****************************************
  // monitor thresholds and gated flags
  // ****************************************
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      HS_DRAIN_THRESH  <= 15'h0000;
      HS_SOURCE_THRESH <= 15'h0000;
      LS_DRAIN_THRESH  <= 18'h0_0000;
      HS_BOOST_REF     <= 5'h00;
      HS_DRIVER_USABLE <= 5'h00;
      HS_DRAIN_FLAG    <= 5'h00;
      HS_SOURCE_FLAG   <= 5'h00;
      LS_DRAIN_FLAG    <= 6'h00;
    end else begin
      HS_DRAIN_THRESH  <= hs_drain_thresh_reg[14:0];
      HS_SOURCE_THRESH <= hs_source_thresh_reg[14:0];
      // six monitored low-side channels; converter driver has none
      LS_DRAIN_THRESH  <= {ls_drain_thresh_reg_b[8:0], ls_drain_thresh_reg_a[8:0]};
      HS_BOOST_REF     <= UC_HS_BOOST_REF & `PDC_HS_BOOST_MASK;
      HS_DRIVER_USABLE <= ~HS_STANDALONE;
      HS_DRAIN_FLAG    <= HS_DRAIN_CMP & HS_SUPPLIED;
      HS_SOURCE_FLAG   <= HS_SOURCE_CMP & HS_SUPPLIED;
      LS_DRAIN_FLAG    <= LS_DRAIN_CMP & LS_SUPPLIED[5:0];
    end
  end

  // ****************************************
  // read back
  // ****************************************
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `PDC_ADDR_HS_DRAIN:    REG_RDATA <= hs_drain_thresh_reg;
        `PDC_ADDR_HS_SOURCE:   REG_RDATA <= hs_source_thresh_reg;
        `PDC_ADDR_LS_DRAIN_A:  REG_RDATA <= ls_drain_thresh_reg_a;
        `PDC_ADDR_LS_DRAIN_B:  REG_RDATA <= ls_drain_thresh_reg_b;
        `PDC_ADDR_LS_STRENGTH: REG_RDATA <= ls_strength_cfg_reg;
        default:               REG_RDATA <= 16'h0000;
      endcase
    end
  end
endmodule // pdc_cfg_bank
`default_nettype wire

// >>> pdc_host_model.sv
// host model driving the register port of the strength bank
// assumes falling-edge drive, one request at a time
`timescale 1ns/100ps
`default_nettype none
module pdc_host_model (
  // clock and mode
  input  wire logic        clk,
  input  wire logic        normal_mode,
  // register port
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  output var  logic [8:0]  reg_addr,
  output var  logic [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  // ********
  // requests
  // ********
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  end
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    if (normal_mode !== 1'b1)
      @(posedge normal_mode);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d; // released data never holds
  endtask
  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    d = reg_rdata;
    reg_rd = 1'b0;
  endtask
endmodule // pdc_host_model
`default_nettype wire

// >>> pdc_cfg_sva.sv
// checker for the strength and threshold bank
// assumes it is bound to pdc_cfg_bank
`timescale 1ns/100ps
`default_nettype none
module pdc_cfg_sva (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        SYS_RST,
  // register port
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [8:0]  REG_ADDR,
  input wire logic [15:0] REG_RDATA,
  input wire logic        REG_ERR,
  // control and stages
  input wire logic        UC_FAST_STRENGTH,
  input wire logic        DEV_OPERATING,
  input wire logic        NORMAL_MODE,
  input wire logic [6:0]  LS_CMD_IN,
  input wire logic [6:0]  LS_GATE,
  input wire logic [27:0] LS_RISE_SEL,
  input wire logic [27:0] LS_FALL_SEL,
  input wire logic [4:0]  HS_DRAIN_CMP,
  input wire logic [4:0]  HS_SUPPLIED,
  input wire logic [4:0]  HS_DRAIN_FLAG
);
  // ********
  // properties
  // ********
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  wire logic hit = (REG_ADDR >= 9'h18A && REG_ADDR <= 9'h18D) || REG_ADDR == 9'h18F;
  sequence s_fast; UC_FAST_STRENGTH; endsequence
  sequence s_all_fast; ##2 (LS_RISE_SEL == 28'h111_1111 && LS_FALL_SEL == 28'h111_1111); endsequence
  a_gate_off: assert property (!DEV_OPERATING |-> LS_GATE == 7'h00)
    else $error("gate on while stopped");
  a_gate_follow: assert property (DEV_OPERATING |-> LS_GATE == LS_CMD_IN)
    else $error("gate differs from command");
  a_fast_force: assert property (s_fast |-> s_all_fast)
    else $error("fast override not applied");
  a_mode_up: assert property (1'b1 |=> NORMAL_MODE)
    else $error("normal mode missing");
  a_map_err: assert property ((REG_WR || REG_RD) |-> REG_ERR == !hit)
    else $error("error flag wrong");
  a_odd_read: assert property (REG_RD && !hit |=> REG_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_flag_supply: assert property (1'b1 |=> HS_DRAIN_FLAG == $past(HS_DRAIN_CMP & HS_SUPPLIED))
    else $error("flag ignores supply");
  a_fall_slower: assert property (LS_FALL_SEL[3:0] >= LS_RISE_SEL[3:0])
    else $error("falling edge faster");
endmodule // pdc_cfg_sva
bind pdc_cfg_bank pdc_cfg_sva chk_u (.*);
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the strength and threshold bank
// assumes host model and bound checker compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ********
  // signals and design
  // ********
  logic        clk_sys, sys_rst, uc_fast, uc_twr, dev_op;
  logic [1:0]  uc_sel;
  logic [15:0] uc_data;
  logic [4:0]  boost, hs_sup, alone, hs_dc, hs_sc;
  logic [6:0]  ls_cmd, ls_sup;
  logic [5:0]  ls_dc;
  wire         wr, rd, normal;
  wire  [8:0]  addr;
  wire  [15:0] wdata, rdata;
  wire  [6:0]  gate;
  wire  [27:0] rise, fall;
  wire  [14:0] hs_dt, hs_st;
  wire  [17:0] ls_dt;
  wire  [4:0]  boost_o, usable;
  wire  [4:0]  hs_df, hs_sf;
  wire  [5:0]  ls_df;
  int          errors, checks_done;
  localparam logic [8:0] AD [4] = '{9'h18A, 9'h18B, 9'h18C, 9'h18D};
  pdc_host_model host_u (.clk(clk_sys), .normal_mode(normal), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));
  pdc_cfg_bank dut_u (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ERR(),
    .UC_FAST_STRENGTH(uc_fast), .UC_THRESH_WR(uc_twr), .UC_THRESH_SEL(uc_sel),
    .UC_THRESH_DATA(uc_data), .UC_HS_BOOST_REF(boost), .DEV_OPERATING(dev_op),
    .LS_CMD_IN(ls_cmd), .HS_SUPPLIED(hs_sup), .LS_SUPPLIED(ls_sup), .HS_STANDALONE(alone),
    .HS_DRAIN_CMP(hs_dc), .HS_SOURCE_CMP(hs_sc), .LS_DRAIN_CMP(ls_dc), .LS_GATE(gate),
    .LS_RISE_SEL(rise), .LS_FALL_SEL(fall), .HS_DRAIN_THRESH(hs_dt),
    .HS_SOURCE_THRESH(hs_st), .LS_DRAIN_THRESH(ls_dt), .HS_BOOST_REF(boost_o),
    .HS_DRIVER_USABLE(usable), .HS_DRAIN_FLAG(hs_df), .HS_SOURCE_FLAG(hs_sf),
    .LS_DRAIN_FLAG(ls_df),
    .NORMAL_MODE(normal));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // slower of the two codes wins on the falling edge
  function automatic logic [27:0] sel(input logic [15:0] v, input logic f);
    logic [1:0] r;
    logic [1:0] c;
    sel = '0;
    for (int i = 0; i < 7; i++) begin
      r = v[2*(i%4) +: 2];
      c = v[8+2*(i%4) +: 2];
      if (f && c > r)
        r = c;
      sel[4*i+r] = 1'b1;
    end
  endfunction
  task automatic stir;
    {boost, hs_sup, alone, hs_dc, hs_sc} = $urandom;
    {ls_cmd, ls_sup, ls_dc, dev_op} = $urandom;
  endtask
  task automatic pulse_uc;
    @(negedge clk_sys);
    uc_twr = 1'b1;
    @(negedge clk_sys);
    uc_twr = 1'b0;
  endtask
  task automatic do_reset;
    sys_rst = 1'b1;
    ls_cmd = 7'h7F;
    dev_op = 1'b1;
    repeat (5) @(negedge clk_sys);
    check(gate, 0);
    check(rise, 28'h111_1111);
    sys_rst = 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ********
  // tests
  // ********
  initial begin
    logic [15:0] d, q, t [4];
    int i;
    void'($urandom(90));
    {uc_fast, uc_twr, uc_sel, uc_data} = '0;
    stir;
    do_reset;
    for (i = 0; i < 4; i++) begin
      host_u.rd(AD[i], q);
      check(q, 0);
    end
    for (i = 0; i < 12; i++) begin
      d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      stir;
      host_u.wr(9'h18F, d);
      repeat (2) @(negedge clk_sys);
      check(rise, sel(d, 0));
      check(fall, sel(d, 1));
      check(gate, dev_op ? ls_cmd : 7'h00);
      check(boost_o, boost & 5'h0A);
      check(usable, 5'(~alone));
      check(hs_df, hs_dc & hs_sup);
      check(hs_sf, hs_sc & hs_sup);
      check(ls_df, ls_dc & ls_sup[5:0]);
      host_u.rd(9'h18F, q);
      check(q, d);
    end
    uc_fast = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(fall, 28'h111_1111);
    check(rise, 28'h111_1111);
    d = 16'h9C63;
    host_u.wr(9'h18F, d);
    @(negedge clk_sys);
    check(rise, 28'h111_1111);
    uc_fast = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(rise, sel(d, 0));
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      t[i] = 16'($urandom);
      uc_sel = i[1:0];
      uc_data = t[i];
      if (i[0]) begin
        host_u.wr(AD[i], d);
        pulse_uc;
      end else begin
        // same-edge spi and microcode write, microcode must win
        fork
          host_u.wr(AD[i], d);
          pulse_uc;
        join
      end
    end
    repeat (2) @(negedge clk_sys);
    check(hs_dt, t[0][14:0]);
    check(hs_st, t[1][14:0]);
    check(ls_dt, {t[3][8:0], t[2][8:0]});
    for (i = 0; i < 4; i++) begin
      host_u.rd(AD[i], q);
      check(q & (i < 2 ? 16'h7FFF : 16'h01FF), t[i] & (i < 2 ? 16'h7FFF : 16'h01FF));
    end
    host_u.rd(9'h18E, q);
    check(q, 0);
    do_reset;
    host_u.wr(9'h18F, 16'h00E4);
    repeat (2) @(negedge clk_sys);
    check(rise, sel(16'h00E4, 0));
    final_report;
  end
  initial begin
    #(3000 * 40);
    errors++;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
